// ### shared/pmc_pkg.sv
// constants for the counter control block: register indices, field spots
// assumes one core clock; model-register port indices are local to block
//
// How it works
// - response nibble: bit11 modified, 9 hit, 8 clean
// - type nibble: bit9 to-invalid, bit8 to-shared
// - each event carries at most one qualifier kind
// - three 40-bit fixed counters, upper write bits zero
// - control bit 0 counts at ring zero
// - control bit 1 counts above ring zero
// - both bits clear stops; both set counts always
// - control bit 3 interrupts on counter overflow
// - fixed counters need no event select
// - global enable bit ANDed with privilege enables
// - overflow status bits 34:32 fixed, 1:0 general
// - status bit 62 flags sample buffer full
// - status bit 63 flags monitoring state change
// - general counter zero overflow arms sampling; next event samples
// - bounds pass: store, clear status, reload counter
// - clear register drops any overflow bit set
// - retirement events count on general counter zero
// - retirement codes C9H/00H and CBH/01H..10H
// - required coherency qualifier empty means no count
package pmc_pkg;

    localparam int CW = 40;
    localparam int NGEN = 2;
    localparam int NFIX = 3;
    localparam int NCNT = 5;
    localparam int AW = 12;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [11:0] A_GEN_BASE = 12'h000;
    localparam logic [11:0] A_SEL_BASE = 12'h002;
    localparam logic [11:0] A_FIX_BASE = 12'h004;
    localparam logic [11:0] A_FIXCTL = 12'h007;
    localparam logic [11:0] A_GLB_EN = 12'h008;
    localparam logic [11:0] A_STATUS = 12'h009;
    localparam logic [11:0] A_OVF_CLR = 12'h00A;
    localparam logic [11:0] A_SMP_EN = 12'h00B;
    localparam logic [11:0] A_RELOAD = 12'h00C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FC_RING0 = 0;
    localparam int FC_RINGN = 1;
    localparam int FC_IRQ = 3;
    localparam int FC_W = 4;
    localparam int ES_UMASK_LSB = 8;
    localparam int ES_USR = 16;
    localparam int ES_OS = 17;
    localparam int ES_INT = 20;
    localparam int ES_EN = 22;
    localparam int UM_MOD_HIT = 11;
    localparam int UM_HIT = 9;
    localparam int UM_CLEAN = 8;
    localparam int UM_TO_INV = 9;
    localparam int UM_TO_SHR = 8;
    localparam int ST_GEN_LSB = 0;
    localparam int ST_FIX_LSB = 32;
    localparam int ST_BUF_FULL = 62;
    localparam int ST_CHG = 63;
    localparam logic [63:0] EN_MASK = 64'h0000_0007_0000_0003;
    localparam logic [63:0] ST_MASK = 64'hC000_0007_0000_0003;
    localparam logic [63:0] RST_ZERO = 64'h0000_0000_0000_0000;

    // ****************************************
    // retirement event codes
    // ****************************************
    localparam logic [7:0] EV_ITLB_RET = 8'hC9;
    localparam logic [7:0] UM_ITLB_RET = 8'h00;
    localparam logic [7:0] EV_LOAD_RET = 8'hCB;
    localparam logic [7:0] UM_L1D_MISS = 8'h01;
    localparam logic [7:0] UM_L1D_LINE = 8'h02;
    localparam logic [7:0] UM_L2_MISS = 8'h04;
    localparam logic [7:0] UM_L2_LINE = 8'h08;
    localparam logic [7:0] UM_DTLB_MISS = 8'h10;

    typedef enum logic [1:0] {QK_NONE, QK_MESI, QK_RESP, QK_TYPE} pmc_qual_e;
    typedef enum logic {SMP_IDLE, SMP_ARMED} pmc_samp_e;

endpackage

// ### src/pmc_global_ctrl.sv
// counters, fixed/global control, overflow status and precise sampling
// assumes event sources and model-register port share CLOCK
`timescale 1ns/1ns
module pmc_global_ctrl (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic MSR_REQ,
    input wire logic MSR_WE,
    input wire logic [11:0] MSR_ADDR,
    input wire logic [63:0] MSR_WDATA,
    output logic MSR_ACK,
    output logic MSR_FAULT,
    output logic [63:0] MSR_RDATA,
    input wire logic CPL_ZERO,
    input wire logic [2:0] FIX_EVENT,
    input wire logic GEN_EV_VALID,
    input wire logic [7:0] GEN_EV_CODE,
    input wire logic [7:0] GEN_EV_UMASK,
    input wire logic [1:0] GEN_EV_QKIND,
    input wire logic [3:0] GEN_EV_QUAL,
    input wire logic GEN_EV_RETIRED,
    input wire logic SAMPLE_BOUNDS_OK,
    input wire logic SAMPLE_BUF_FILLED,
    output logic SAMPLE_STORE,
    output logic OVF_IRQ
);

    localparam int CW = pmc_pkg::CW;
    localparam int NGEN = pmc_pkg::NGEN;
    localparam int NCNT = pmc_pkg::NCNT;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [11:0] cnt_addr(input int k);
        if (k < NGEN) begin
            cnt_addr = pmc_pkg::A_GEN_BASE + 12'(k);
        end else begin
            cnt_addr = pmc_pkg::A_FIX_BASE + 12'(k - NGEN);
        end
    endfunction

    function automatic logic is_ret(input logic [7:0] code, input logic [7:0] um);
        is_ret = (code == pmc_pkg::EV_ITLB_RET && um == pmc_pkg::UM_ITLB_RET)
            || (code == pmc_pkg::EV_LOAD_RET
            && um inside {pmc_pkg::UM_L1D_MISS, pmc_pkg::UM_L1D_LINE,
            pmc_pkg::UM_L2_MISS, pmc_pkg::UM_L2_LINE, pmc_pkg::UM_DTLB_MISS});
    endfunction

    // one qualifier kind per event; nibble is umask bits 11:8
    function automatic logic qual_ok(input logic [1:0] kind, input logic [3:0] um,
        input logic [3:0] q);
        case (pmc_pkg::pmc_qual_e'(kind))
            pmc_pkg::QK_NONE: qual_ok = 1'b1;
            pmc_pkg::QK_MESI: qual_ok = |(um & q);
            pmc_pkg::QK_RESP: begin
                // bit 10 reserved, never matches
                qual_ok = (um[pmc_pkg::UM_MOD_HIT - 8] & q[pmc_pkg::UM_MOD_HIT - 8])
                    | (um[pmc_pkg::UM_HIT - 8] & q[pmc_pkg::UM_HIT - 8])
                    | (um[pmc_pkg::UM_CLEAN - 8] & q[pmc_pkg::UM_CLEAN - 8]);
            end
            pmc_pkg::QK_TYPE: begin
                qual_ok = (um[pmc_pkg::UM_TO_INV - 8] & q[pmc_pkg::UM_TO_INV - 8])
                    | (um[pmc_pkg::UM_TO_SHR - 8] & q[pmc_pkg::UM_TO_SHR - 8]);
            end
            default: qual_ok = 1'b0;
        endcase
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [CW-1:0] cnt_reg [NCNT];
    logic [31:0] sel_reg [NGEN];
    logic [11:0] fc_reg;
    logic [63:0] en_reg;
    logic [63:0] st_reg;
    logic [63:0] st_next;
    logic [63:0] st_set;
    logic [63:0] st_clr;
    logic smp_en_reg;
    logic [CW-1:0] reload_reg;
    pmc_pkg::pmc_samp_e smp_reg;
    pmc_pkg::pmc_samp_e smp_next;
    logic [NCNT-1:0] inc;
    logic [NCNT-1:0] wrap;
    logic [NCNT-1:0] cnt_wr;
    logic msr_wr;
    logic upper_bad;
    logic cnt_hit;
    logic fault_now;
    logic cfg_wr;
    logic ovf_wr;
    logic smp_fire;
    logic smp_store_now;
    logic irq_now;
    logic [63:0] rd_data;

    assign msr_wr = MSR_REQ & MSR_WE;
    assign upper_bad = |MSR_WDATA[63:CW];
    assign ovf_wr = msr_wr & (MSR_ADDR == pmc_pkg::A_OVF_CLR);
    assign cfg_wr = msr_wr & !fault_now & (MSR_ADDR == pmc_pkg::A_FIXCTL
        || MSR_ADDR == pmc_pkg::A_GLB_EN || MSR_ADDR == pmc_pkg::A_SMP_EN
        || MSR_ADDR == pmc_pkg::A_SEL_BASE || MSR_ADDR == pmc_pkg::A_SEL_BASE + 12'h001);

    // ****************************************
    // count qualification
    // ****************************************
    always_comb begin
        for (int i = 0; i < NGEN; i++) begin
            inc[i] = sel_reg[i][pmc_pkg::ES_EN] & en_reg[pmc_pkg::ST_GEN_LSB + i]
                & ((CPL_ZERO & sel_reg[i][pmc_pkg::ES_OS])
                | (!CPL_ZERO & sel_reg[i][pmc_pkg::ES_USR]))
                & GEN_EV_VALID & (GEN_EV_CODE == sel_reg[i][7:0])
                & (GEN_EV_QKIND == 2'(pmc_pkg::QK_NONE)
                ? GEN_EV_UMASK == sel_reg[i][15:8]
                : GEN_EV_UMASK[7:4] == sel_reg[i][15:12])
                & qual_ok(GEN_EV_QKIND, sel_reg[i][11:8], GEN_EV_QUAL)
                & (!is_ret(sel_reg[i][7:0], sel_reg[i][15:8])
                || (i == 0 && GEN_EV_RETIRED));
        end
        for (int j = 0; j < pmc_pkg::NFIX; j++) begin
            // fixed counters read only their control nibble
            inc[NGEN + j] = FIX_EVENT[j] & en_reg[pmc_pkg::ST_FIX_LSB + j]
                & ((CPL_ZERO & fc_reg[j * pmc_pkg::FC_W + pmc_pkg::FC_RING0])
                | (!CPL_ZERO & fc_reg[j * pmc_pkg::FC_W + pmc_pkg::FC_RINGN]));
        end
        for (int k = 0; k < NCNT; k++) begin
            wrap[k] = inc[k] & (&cnt_reg[k]);
            cnt_wr[k] = msr_wr & (MSR_ADDR == cnt_addr(k)) & !upper_bad;
        end
    end

    // ****************************************
    // counters
    // ****************************************
    always_ff @(posedge CLOCK) begin
        for (int k = 0; k < NCNT; k++) begin
            if (SRST) begin
                cnt_reg[k] <= '0;
            end else if (cnt_wr[k]) begin
                cnt_reg[k] <= MSR_WDATA[CW-1:0];
            end else if (k == 0 && smp_store_now) begin
                cnt_reg[k] <= reload_reg;
            end else if (inc[k]) begin
                cnt_reg[k] <= cnt_reg[k] + 1'b1;
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            fc_reg <= '0;
            en_reg <= pmc_pkg::RST_ZERO;
            smp_en_reg <= 1'b0;
            reload_reg <= '0;
            for (int i = 0; i < NGEN; i++) begin
                sel_reg[i] <= '0;
            end
        end else if (msr_wr) begin
            if (MSR_ADDR == pmc_pkg::A_FIXCTL) begin
                fc_reg <= MSR_WDATA[11:0];
            end
            if (MSR_ADDR == pmc_pkg::A_GLB_EN) begin
                en_reg <= MSR_WDATA & pmc_pkg::EN_MASK;
            end
            if (MSR_ADDR == pmc_pkg::A_SMP_EN) begin
                smp_en_reg <= MSR_WDATA[0];
            end
            if (MSR_ADDR == pmc_pkg::A_RELOAD && !upper_bad) begin
                reload_reg <= MSR_WDATA[CW-1:0];
            end
            for (int i = 0; i < NGEN; i++) begin
                if (MSR_ADDR == pmc_pkg::A_SEL_BASE + 12'(i)) begin
                    sel_reg[i] <= MSR_WDATA[31:0];
                end
            end
        end
    end

    // ****************************************
    // precise sampling on general counter zero
    // ****************************************
    assign smp_fire = (smp_reg == pmc_pkg::SMP_ARMED) & inc[0];
    assign smp_store_now = smp_fire & SAMPLE_BOUNDS_OK;

    always_comb begin
        smp_next = smp_reg;
        case (smp_reg)
            pmc_pkg::SMP_IDLE: begin
                if (wrap[0] && smp_en_reg) begin
                    smp_next = pmc_pkg::SMP_ARMED;
                end
            end
            pmc_pkg::SMP_ARMED: begin
                // failed bounds check drops the sample too
                if (smp_fire || !smp_en_reg) begin
                    smp_next = pmc_pkg::SMP_IDLE;
                end
            end
            default: smp_next = pmc_pkg::SMP_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            smp_reg <= pmc_pkg::SMP_IDLE;
            SAMPLE_STORE <= 1'b0;
        end else begin
            smp_reg <= smp_next;
            SAMPLE_STORE <= smp_store_now;
        end
    end

    // ****************************************
    // overflow status, set beats clear
    // ****************************************
    always_comb begin
        st_set = '0;
        st_set[pmc_pkg::ST_GEN_LSB +: NGEN] = wrap[NGEN-1:0];
        st_set[pmc_pkg::ST_FIX_LSB +: pmc_pkg::NFIX] = wrap[NCNT-1:NGEN];
        st_set[pmc_pkg::ST_BUF_FULL] = SAMPLE_BUF_FILLED;
        st_set[pmc_pkg::ST_CHG] = cfg_wr;
        st_clr = ovf_wr ? (MSR_WDATA & pmc_pkg::ST_MASK) : '0;
        st_clr[pmc_pkg::ST_GEN_LSB] = st_clr[pmc_pkg::ST_GEN_LSB] | smp_store_now;
        st_next = (st_reg & ~st_clr) | st_set;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_reg <= pmc_pkg::RST_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // overflow interrupt to local controller
    // ****************************************
    always_comb begin
        irq_now = 1'b0;
        for (int i = 0; i < NGEN; i++) begin
            irq_now = irq_now | (wrap[i] & sel_reg[i][pmc_pkg::ES_INT]);
        end
        for (int j = 0; j < pmc_pkg::NFIX; j++) begin
            irq_now = irq_now | (wrap[NGEN + j]
                & fc_reg[j * pmc_pkg::FC_W + pmc_pkg::FC_IRQ]);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            OVF_IRQ <= 1'b0;
        end else begin
            OVF_IRQ <= irq_now;
        end
    end

    // ****************************************
    // model-register port
    // ****************************************
    always_comb begin
        rd_data = '0;
        cnt_hit = 1'b0;
        for (int k = 0; k < NCNT; k++) begin
            if (MSR_ADDR == cnt_addr(k)) begin
                rd_data = {{(64 - CW){1'b0}}, cnt_reg[k]};
                cnt_hit = 1'b1;
            end
        end
        for (int i = 0; i < NGEN; i++) begin
            if (MSR_ADDR == pmc_pkg::A_SEL_BASE + 12'(i)) begin
                rd_data = {32'h0000_0000, sel_reg[i]};
            end
        end
        case (MSR_ADDR)
            pmc_pkg::A_FIXCTL: rd_data = {52'h0_0000_0000_0000, fc_reg};
            pmc_pkg::A_GLB_EN: rd_data = en_reg;
            pmc_pkg::A_STATUS: rd_data = st_reg;
            pmc_pkg::A_SMP_EN: rd_data = {63'h0, smp_en_reg};
            pmc_pkg::A_RELOAD: rd_data = {{(64 - CW){1'b0}}, reload_reg};
            default: ;
        endcase
        // unmapped, read-only status, write-only clear, wide counter or reload data
        fault_now = 1'b0;
        if (!cnt_hit && !(MSR_ADDR inside {pmc_pkg::A_FIXCTL, pmc_pkg::A_GLB_EN,
            pmc_pkg::A_STATUS, pmc_pkg::A_OVF_CLR, pmc_pkg::A_SMP_EN,
            pmc_pkg::A_RELOAD, pmc_pkg::A_SEL_BASE, pmc_pkg::A_SEL_BASE + 12'h001})) begin
            fault_now = 1'b1;
        end else if (MSR_WE && MSR_ADDR == pmc_pkg::A_STATUS) begin
            fault_now = 1'b1;
        end else if (!MSR_WE && MSR_ADDR == pmc_pkg::A_OVF_CLR) begin
            fault_now = 1'b1;
        end else if (MSR_WE && (cnt_hit || MSR_ADDR == pmc_pkg::A_RELOAD) && upper_bad) begin
            fault_now = 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            MSR_ACK <= 1'b0;
            MSR_FAULT <= 1'b0;
            MSR_RDATA <= '0;
        end else begin
            MSR_ACK <= MSR_REQ;
            MSR_FAULT <= MSR_REQ & fault_now;
            MSR_RDATA <= (MSR_REQ && !MSR_WE && !fault_now) ? rd_data : '0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    fix_stop_a: assert property (fc_reg[1:0] == 2'b00 && !cnt_wr[2]
        |=> $stable(cnt_reg[2])) else $error("stopped fixed counter moved");
    gate_and_a: assert property (!en_reg[pmc_pkg::ST_FIX_LSB] && !cnt_wr[2]
        |=> cnt_reg[2] == $past(cnt_reg[2])) else $error("gated counter moved");
    ring_zero_a: assert property (FIX_EVENT[0] && CPL_ZERO && fc_reg[0] && !cnt_wr[2]
        && en_reg[pmc_pkg::ST_FIX_LSB] && !(&cnt_reg[2])
        |=> cnt_reg[2] == $past(cnt_reg[2]) + 1'b1) else $error("ring zero event missed");
    ring_high_a: assert property (!CPL_ZERO && !fc_reg[1] |-> !inc[2])
        else $error("counted above ring zero");
    wrap_set_a: assert property (wrap[3] && !cnt_wr[3]
        |=> st_reg[pmc_pkg::ST_FIX_LSB + 1] && cnt_reg[3] == '0) else $error("wrap lost");
    sticky_ovf_a: assert property (st_reg[33] && !(ovf_wr && MSR_WDATA[33])
        |=> st_reg[33]) else $error("overflow bit dropped");
    clear_ovf_a: assert property (ovf_wr && MSR_WDATA[34] && !wrap[4]
        |=> !st_reg[34]) else $error("overflow clear ignored");
    irq_fix_a: assert property (wrap[3] && fc_reg[pmc_pkg::FC_W + pmc_pkg::FC_IRQ]
        |=> OVF_IRQ) else $error("overflow interrupt missing");
    chg_flag_a: assert property (cfg_wr ##1 !(ovf_wr && MSR_WDATA[63])
        |-> st_reg[63]) else $error("change flag not set");
    buf_full_a: assert property (SAMPLE_BUF_FILLED |=> st_reg[62])
        else $error("buffer full flag not set");
    retire_only_a: assert property (is_ret(sel_reg[1][7:0], sel_reg[1][15:8])
        |-> !inc[1]) else $error("retire event on counter one");
    arm_sample_a: assert property (smp_fire && SAMPLE_BOUNDS_OK
        |=> SAMPLE_STORE ##1 !SAMPLE_STORE) else $error("sample not stored");
    store_reload_a: assert property (smp_store_now && !cnt_wr[0] && !wrap[0]
        |=> cnt_reg[0] == $past(reload_reg) && !st_reg[0]) else $error("no reload");
    wide_fault_a: assert property (msr_wr && cnt_wr == '0 && cnt_hit && upper_bad
        |=> MSR_FAULT && MSR_ACK) else $error("wide counter write accepted");

endmodule

// ### dv/pmc_core_model.sv
// stand-in for the core event sources and the local interrupt controller
// assumes the block clock; tasks start and end just after a rising edge
`timescale 1ns/1ns
module pmc_core_model (
    input wire logic clk,
    input wire logic ovf_irq,
    input wire logic sample_store,
    output logic cpl_zero,
    output logic [2:0] fix_event,
    output logic gen_valid,
    output logic [7:0] gen_code,
    output logic [7:0] gen_umask,
    output logic [1:0] gen_qkind,
    output logic [3:0] gen_qual,
    output logic gen_retired,
    output logic bounds_ok,
    output logic buf_filled
);
    int irq_count = 0;
    int store_count = 0;
    initial begin
        {cpl_zero, fix_event, gen_valid, gen_code, gen_umask, gen_qkind} = '0;
        {gen_qual, gen_retired, bounds_ok, buf_filled} = '0;
    end
    // ****************************************
    // interrupt sink and event drivers
    // ****************************************
    always @(posedge clk) begin
        if (ovf_irq === 1'b1) irq_count++;
        if (sample_store === 1'b1) store_count++;
    end
    // one event cycle; qualifiers scrambled once released
    task automatic pulse(input logic c, input logic b, input logic [2:0] fx, input logic v,
        input logic [7:0] code, input logic [7:0] um, input logic [1:0] qk,
        input logic [3:0] q, input logic rt);
        {cpl_zero, bounds_ok, fix_event, gen_valid} = {c, b, fx, v};
        {gen_code, gen_umask, gen_qkind, gen_qual, gen_retired} = {code, um, qk, q, rt};
        @(posedge clk);
        #5;
        {fix_event, gen_valid} = 4'h0;
        {gen_code, gen_umask, gen_qkind, gen_qual, gen_retired} = ~{code, um, qk, q, rt};
        @(posedge clk);
        #5;
    endtask
    task automatic fill();
        buf_filled = 1'b1;
        @(posedge clk);
        #5;
        buf_filled = 1'b0;
        @(posedge clk);
        #5;
    endtask
endmodule

// ### dv/pmc_global_ctrl_test.sv
// self-checking bench for the counter control block
// assumes pmc_core_model drives events and counts interrupts and stores
`timescale 1ns/1ns
module pmc_global_ctrl_test;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic msr_req = 1'b0;
    logic msr_we = 1'b0;
    logic [11:0] msr_addr = 12'h000;
    logic [63:0] msr_wdata = 64'h0;
    logic msr_ack, msr_fault, sample_store, ovf_irq;
    logic [63:0] msr_rdata;
    logic cpl_zero, gen_valid, gen_retired, bounds_ok, buf_filled;
    logic [2:0] fix_event;
    logic [7:0] gen_code, gen_umask;
    logic [1:0] gen_qkind;
    logic [3:0] gen_qual;
    logic [31:0] seed = 32'h55C554CE;
    int mismatches = 0;
    int compares = 0;
    // qualifier kind, select nibble, event bits, expected count
    logic [10:0] qtab [9] = '{11'h511, 11'h445, 11'h423, 11'h488, 11'h523, 11'h645,
        11'h624, 11'h202, 11'h289};
    // unit mask and code of each retirement event
    logic [15:0] rtab [6] = '{16'h00C9, 16'h01CB, 16'h02CB, 16'h04CB, 16'h08CB, 16'h10CB};
    always #25 clock = ~clock;
    pmc_global_ctrl uut (
        .CLOCK(clock), .SRST(srst), .MSR_REQ(msr_req), .MSR_WE(msr_we), .MSR_ADDR(msr_addr),
        .MSR_WDATA(msr_wdata), .MSR_ACK(msr_ack), .MSR_FAULT(msr_fault),
        .MSR_RDATA(msr_rdata), .CPL_ZERO(cpl_zero), .FIX_EVENT(fix_event),
        .GEN_EV_VALID(gen_valid), .GEN_EV_CODE(gen_code), .GEN_EV_UMASK(gen_umask),
        .GEN_EV_QKIND(gen_qkind), .GEN_EV_QUAL(gen_qual), .GEN_EV_RETIRED(gen_retired),
        .SAMPLE_BOUNDS_OK(bounds_ok), .SAMPLE_BUF_FILLED(buf_filled),
        .SAMPLE_STORE(sample_store), .OVF_IRQ(ovf_irq)
    );
    pmc_core_model core (
        .clk(clock), .ovf_irq(ovf_irq), .sample_store(sample_store), .cpl_zero(cpl_zero),
        .fix_event(fix_event), .gen_valid(gen_valid), .gen_code(gen_code),
        .gen_umask(gen_umask), .gen_qkind(gen_qkind), .gen_qual(gen_qual),
        .gen_retired(gen_retired), .bounds_ok(bounds_ok), .buf_filled(buf_filled)
    );
    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic we, input logic [11:0] a, input logic [63:0] d,
        input logic [63:0] exp, input logic fexp);
        {msr_req, msr_we, msr_addr, msr_wdata} = {1'b1, we, a, d};
        @(posedge clock);
        #5;
        chk({msr_ack, msr_fault}, {1'b1, fexp}, "answer");
        if (!we) chk(msr_rdata, exp, "read data");
        {msr_req, msr_we, msr_addr, msr_wdata} = {1'b0, ~we, ~a, ~d};
        @(posedge clock);
        #5;
    endtask
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        acc(1'b1, a, d, 64'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [63:0] e);
        acc(1'b0, a, 64'h0, e, 1'b0);
    endtask
    task automatic gev(input logic b, input logic [7:0] code, input logic [7:0] um,
        input logic [1:0] qk, input logic [3:0] q, input logic rt);
        core.pulse(1'b1, b, 3'b000, 1'b1, code, um, qk, q, rt);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 50);
        mismatches++;
        final_report();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [63:0] st, e, rl;
        logic [3:0] nb, q, hn;
        logic [1:0] qk;
        logic ok;
        int j, m, g, c, n;
        repeat (4) @(posedge clock);
        #5;
        srst = 1'b0;
        @(posedge clock);
        #5;
        acc(1'b0, pmc_pkg::A_OVF_CLR, 64'h0, 64'h0, 1'b1);
        acc(1'b1, pmc_pkg::A_STATUS, '1, 64'h0, 1'b1);
        acc(1'b0, 12'h0FF, 64'h0, 64'h0, 1'b1);
        acc(1'b1, pmc_pkg::A_FIX_BASE, 64'h100_0000_0000, 64'h0, 1'b1);
        rd(pmc_pkg::A_FIX_BASE, 64'h0);
        wr(pmc_pkg::A_GLB_EN, '1);
        rd(pmc_pkg::A_GLB_EN, pmc_pkg::EN_MASK);
        rd(pmc_pkg::A_STATUS, 64'h8000_0000_0000_0000);
        wr(pmc_pkg::A_OVF_CLR, '1);
        rd(pmc_pkg::A_STATUS, 64'h0);
        $display("test access done");
        for (int k = 0; k < 48; k++) begin
            j = k % 3;
            m = (k / 3) % 4;
            g = (k / 12) % 2;
            c = k / 24;
            st = {24'h0, rnd(), 8'h00};
            n = rnd() % 4 + 1;
            wr(pmc_pkg::A_FIXCTL, 64'(m) << (4 * j));
            wr(pmc_pkg::A_GLB_EN, 64'(g) << (32 + j));
            wr(pmc_pkg::A_FIX_BASE + 12'(j), st);
            repeat (n) core.pulse(c[0], 1'b1, 3'(rnd()) | (3'b001 << j), 1'b0, 8'h00,
                8'h00, 2'd0, 4'h0, 1'b0);
            e = st + ((g == 1 && (c == 1 ? m % 2 : m / 2) == 1) ? n : 0);
            rd(pmc_pkg::A_FIX_BASE + 12'(j), e);
        end
        $display("test privilege done");
        wr(pmc_pkg::A_OVF_CLR, '1);
        wr(pmc_pkg::A_FIXCTL, 64'h3B0);
        wr(pmc_pkg::A_GLB_EN, 64'h6_0000_0000);
        n = core.irq_count;
        for (int r = 0; r < 2; r++) begin
            wr(pmc_pkg::A_FIX_BASE + 12'h1, 64'hFF_FFFF_FFFF);
            wr(pmc_pkg::A_FIX_BASE + 12'h2, 64'hFF_FFFF_FFFF);
            core.pulse(1'b0, 1'b1, 3'b110, 1'b0, 8'h00, 8'h00, 2'd0, 4'h0, 1'b0);
            rd(pmc_pkg::A_FIX_BASE + 12'h1, 64'h0);
            rd(pmc_pkg::A_STATUS, 64'h8000_0006_0000_0000);
            chk(core.irq_count - n, r + 1, "interrupts");
        end
        n = core.irq_count;
        wr(pmc_pkg::A_FIX_BASE + 12'h2, 64'hFF_FFFF_FFFF);
        core.pulse(1'b0, 1'b1, 3'b100, 1'b0, 8'h00, 8'h00, 2'd0, 4'h0, 1'b0);
        chk(core.irq_count - n, 0, "masked interrupt");
        wr(pmc_pkg::A_OVF_CLR, 64'h2_0000_0000);
        rd(pmc_pkg::A_STATUS, 64'h8000_0004_0000_0000);
        $display("test overflow done");
        wr(pmc_pkg::A_GLB_EN, 64'h1);
        for (int i = 0; i < 9; i++) begin
            {qk, nb, q, ok} = qtab[i];
            hn = 4'(rnd());
            wr(pmc_pkg::A_SEL_BASE, 64'h43_002E | {hn, nb, 8'h00});
            wr(pmc_pkg::A_GEN_BASE, 64'h0);
            gev(1'b1, 8'h2E, {hn, 4'(rnd())}, qk, q, 1'b0);
            rd(pmc_pkg::A_GEN_BASE, 64'(ok));
        end
        wr(pmc_pkg::A_SEL_BASE, 64'h51_002E);
        wr(pmc_pkg::A_GEN_BASE, 64'hFF_FFFF_FFFF);
        n = core.irq_count;
        core.pulse(1'b0, 1'b1, 3'b000, 1'b1, 8'h2E, 8'h00, 2'd0, 4'h0, 1'b0);
        rd(pmc_pkg::A_GEN_BASE, 64'h0);
        chk(core.irq_count - n, 1, "general interrupt");
        $display("test qualifiers done");
        wr(pmc_pkg::A_GLB_EN, 64'h3);
        for (int i = 0; i < 6; i++) begin
            wr(pmc_pkg::A_SEL_BASE, 64'h43_0000 | rtab[i]);
            wr(pmc_pkg::A_SEL_BASE + 12'h1, 64'h43_0000 | rtab[i]);
            wr(pmc_pkg::A_GEN_BASE, 64'h0);
            wr(pmc_pkg::A_GEN_BASE + 12'h1, 64'h0);
            gev(1'b1, rtab[i][7:0], rtab[i][15:8], 2'd0, 4'h0, 1'b0);
            gev(1'b1, rtab[i][7:0], rtab[i][15:8], 2'd0, 4'h0, 1'b1);
            rd(pmc_pkg::A_GEN_BASE, 64'h1);
            rd(pmc_pkg::A_GEN_BASE + 12'h1, 64'h0);
        end
        $display("test retirement done");
        rl = {24'h0, rnd(), 8'h00};
        wr(pmc_pkg::A_OVF_CLR, '1);
        wr(pmc_pkg::A_SEL_BASE, 64'h43_002E);
        wr(pmc_pkg::A_GLB_EN, 64'h1);
        wr(pmc_pkg::A_SMP_EN, 64'h1);
        wr(pmc_pkg::A_RELOAD, rl);
        n = core.store_count;
        for (int r = 0; r < 2; r++) begin
            wr(pmc_pkg::A_GEN_BASE, 64'hFF_FFFF_FFFF);
            gev(1'b1, 8'h2E, 8'h00, 2'd0, 4'h0, 1'b0);
            rd(pmc_pkg::A_STATUS, 64'h8000_0000_0000_0001);
            gev(r == 0, 8'h2E, 8'h00, 2'd0, 4'h0, 1'b0);
            rd(pmc_pkg::A_GEN_BASE, r == 0 ? rl : 64'h1);
            rd(pmc_pkg::A_STATUS, {1'b1, 62'h0, r == 1});
            chk(core.store_count - n, 1, "stores");
        end
        core.fill();
        rd(pmc_pkg::A_STATUS, 64'hC000_0000_0000_0001);
        $display("test sampling done");
        final_report();
    end
endmodule
